/* design/hsc_pkg.sv */
package hsc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] HSC_CAP_DWORD_ADDR = 8'he4;   // dword holding id, next item, control/status
    localparam logic [7:0] HSC_CAP_ID_OFFSET  = 8'he4;
    localparam logic [7:0] HSC_NEXT_OFFSET    = 8'he5;
    localparam logic [7:0] HSC_CTRL_OFFSET    = 8'he6;

    // fixed read values
    localparam logic [7:0] HSC_CAP_ID_VAL     = 8'h06;
    localparam logic [7:0] HSC_NEXT_ITEM_VAL  = 8'h00;
    localparam logic [1:0] HSC_PROG_IFACE_VAL = 2'h1;

    // byte lanes of the dword
    localparam int HSC_LANE_CAP_ID = 0;
    localparam int HSC_LANE_NEXT   = 1;
    localparam int HSC_LANE_CTRL   = 2;
    localparam int HSC_LANE_TOP    = 3;

    // control/status field positions inside the dword
    localparam int HSC_BIT_HIDE_ARM     = 16;
    localparam int HSC_BIT_ENUM_MASK    = 17;
    localparam int HSC_BIT_PENDING      = 18;
    localparam int HSC_BIT_LED          = 19;
    localparam int HSC_BIT_PI_LO        = 20;
    localparam int HSC_BIT_PI_HI        = 21;
    localparam int HSC_BIT_REMOVAL      = 22;
    localparam int HSC_BIT_FRESH_SEAT   = 23;

    // reset values
    localparam logic HSC_RST_HIDE_ARM  = 1'b0;
    localparam logic HSC_RST_ENUM_MASK = 1'b0;
    localparam logic HSC_RST_LED       = 1'b0;
    localparam logic HSC_RST_REMOVAL   = 1'b0;
    localparam logic HSC_RST_FRESH     = 1'b0;
    localparam logic HSC_PENDING_VAL   = 1'b0;

    // configuration request carried as one bundle
    typedef struct packed {
        logic        req;     // access strobe, one access per cycle high
        logic        we;      // 1 write, 0 read
        logic [7:2]  addr;    // dword address
        logic [3:0]  be_n;    // active-low byte enables
        logic [31:0] wdata;
    } hsc_cfg_req_s;

endpackage

/* design/hsc_regs.sv */
`timescale 1ns/1ns
module hsc_regs
    import hsc_pkg::*;
(
    // clock and primary reset
    input  wire logic          i_core_clk,
    input  wire logic          i_arst_n,
    // configuration access from the primary bus target
    input  wire hsc_cfg_req_s  i_cfg,
    output logic               o_cfg_ack,
    output logic [31:0]        o_cfg_rdata,
    // board events
    input  wire logic          i_removal_req,
    input  wire logic          i_ejector_closed,
    // outputs to pins and bridge core
    output logic               o_bus_quiet,
    output logic               o_enum_out_n,
    output logic               o_led_on
);

    // ------------------------------------------------------------
    // operating notes
    // ------------------------------------------------------------
    // access timing:
    //   a request is taken on the edge where req is high and the
    //   bridge is not hidden; ack and read data follow one edge later
    //   and stand for one cycle for each cycle that req is high.
    //   read data is zero outside the ack cycle and for any dword
    //   other than the capability dword.
    // byte lanes:
    //   only lane 2 (control/status) holds writable state; lanes 0, 1
    //   and 3 are fixed and silently ignore writes.
    // hiding:
    //   the hide bit is raised one edge after reset release and, as a
    //   hidden bridge takes no configuration access, only a new reset
    //   lowers it again. a user must know this: the block stays quiet
    //   for the rest of the reset period.
    // flags:
    //   removal and fresh-seat flags are sticky; a write of 1 clears
    //   them, a write of 0 keeps them. an event in the clearing cycle
    //   wins, so no event is ever lost to a racing clear.
    //   fresh seat is taken once per reset, on the first cycle after
    //   release where the handle is seen closed; a board already
    //   seated at release therefore counts as freshly inserted.
    // enumeration pin:
    //   computed from the next flag and mask values so the pin moves in
    //   the same cycle as the flags it reflects, at the cost of a longer
    //   combinational path into its flop.
    // led:
    //   the led output is the stored control bit, nothing more; any pin
    //   drive strength or polarity inversion lives outside this block.
    // ------------------------------------------------------------

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic        hide_arm;
    logic        enum_irq_mask;
    logic        led_on_off;
    logic        removal_pending_flag;
    logic        fresh_seat_flag;
    logic        out_of_reset;
    logic        ejector_seen;
    logic        cfg_ack;
    logic [31:0] cfg_rdata;
    logic        enum_out_n;

    logic        next_hide_arm;
    logic        next_enum_irq_mask;
    logic        next_led_on_off;
    logic        next_removal_pending_flag;
    logic        next_fresh_seat_flag;
    logic        next_out_of_reset;
    logic        next_ejector_seen;
    logic        next_cfg_ack;
    logic [31:0] next_cfg_rdata;
    logic        next_enum_out_n;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // a byte lane is written when its active-low enable is low
    function automatic logic lane_on(input logic [3:0] be_n, input int lane);
        lane_on = ~be_n[lane];
    endfunction

    function automatic logic [31:0] cap_dword(
        input logic hide, input logic mask, input logic led,
        input logic rem,  input logic fresh);
        logic [31:0] d;
        d = '0;
        d[HSC_LANE_CAP_ID*8 +: 8]        = HSC_CAP_ID_VAL;
        d[HSC_LANE_NEXT*8 +: 8]          = HSC_NEXT_ITEM_VAL;
        d[HSC_BIT_HIDE_ARM]              = hide;
        d[HSC_BIT_ENUM_MASK]             = mask;
        d[HSC_BIT_PENDING]               = HSC_PENDING_VAL;
        d[HSC_BIT_LED]                   = led;
        d[HSC_BIT_PI_HI:HSC_BIT_PI_LO]   = HSC_PROG_IFACE_VAL;
        d[HSC_BIT_REMOVAL]               = rem;
        d[HSC_BIT_FRESH_SEAT]            = fresh;
        cap_dword = d;
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // access decode, flag update and enumeration output
    always_comb
    begin
        logic hit;
        logic ctrl_wr;
        logic fresh_evt;
        hit       = (i_cfg.addr == HSC_CAP_DWORD_ADDR[7:2]);
        ctrl_wr   = i_cfg.req && i_cfg.we && hit && lane_on(i_cfg.be_n, HSC_LANE_CTRL);
        // closure seen first after release; a board seated at release counts too
        fresh_evt = out_of_reset && i_ejector_closed && !ejector_seen;

        next_out_of_reset = 1'b1;
        next_ejector_seen = ejector_seen || (out_of_reset && i_ejector_closed);

        // hidden bridge takes no access at all
        next_cfg_ack   = i_cfg.req && !hide_arm;
        next_cfg_rdata = '0;
        if (i_cfg.req && !hide_arm && !i_cfg.we && hit)
        begin
            next_cfg_rdata = cap_dword(hide_arm, enum_irq_mask, led_on_off,
                                       removal_pending_flag, fresh_seat_flag);
        end

        next_hide_arm      = hide_arm;
        next_enum_irq_mask = enum_irq_mask;
        next_led_on_off    = led_on_off;
        if (ctrl_wr && !hide_arm)
        begin
            next_hide_arm      = i_cfg.wdata[HSC_BIT_HIDE_ARM];
            next_enum_irq_mask = i_cfg.wdata[HSC_BIT_ENUM_MASK];
            next_led_on_off    = i_cfg.wdata[HSC_BIT_LED];
        end
        if (!out_of_reset)
        begin
            next_hide_arm = 1'b1;
        end

        // write-one-to-clear, but a new event wins over the clear
        next_removal_pending_flag = removal_pending_flag;
        next_fresh_seat_flag      = fresh_seat_flag;
        if (ctrl_wr && !hide_arm && i_cfg.wdata[HSC_BIT_REMOVAL])
        begin
            next_removal_pending_flag = 1'b0;
        end
        if (ctrl_wr && !hide_arm && i_cfg.wdata[HSC_BIT_FRESH_SEAT])
        begin
            next_fresh_seat_flag = 1'b0;
        end
        if (i_removal_req)
        begin
            next_removal_pending_flag = 1'b1;
        end
        if (fresh_evt)
        begin
            next_fresh_seat_flag = 1'b1;
        end

        next_enum_out_n = !((next_removal_pending_flag || next_fresh_seat_flag) && !next_enum_irq_mask);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // primary reset clears everything but enum_out_n, which it sets high; hide arm is raised one edge later
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            hide_arm             <= HSC_RST_HIDE_ARM;
            enum_irq_mask        <= HSC_RST_ENUM_MASK;
            led_on_off           <= HSC_RST_LED;
            removal_pending_flag <= HSC_RST_REMOVAL;
            fresh_seat_flag      <= HSC_RST_FRESH;
            out_of_reset         <= 1'b0;
            ejector_seen         <= 1'b0;
            cfg_ack              <= 1'b0;
            cfg_rdata            <= '0;
            enum_out_n           <= 1'b1;
        end
        else
        begin
            hide_arm             <= next_hide_arm;
            enum_irq_mask        <= next_enum_irq_mask;
            led_on_off           <= next_led_on_off;
            removal_pending_flag <= next_removal_pending_flag;
            fresh_seat_flag      <= next_fresh_seat_flag;
            out_of_reset         <= next_out_of_reset;
            ejector_seen         <= next_ejector_seen;
            cfg_ack              <= next_cfg_ack;
            cfg_rdata            <= next_cfg_rdata;
            enum_out_n           <= next_enum_out_n;
        end
    end

    // outputs straight from flops
    assign o_cfg_ack    = cfg_ack;
    assign o_cfg_rdata  = cfg_rdata;
    assign o_bus_quiet  = hide_arm;
    assign o_enum_out_n = enum_out_n;
    assign o_led_on     = led_on_off;

endmodule

/* verification/hsc_cfg_master.sv */
`timescale 1ns/1ns
module hsc_cfg_master
    import hsc_pkg::*;
(
    // clock and stimulus
    input  wire logic        i_core_clk,
    input  wire logic        i_en,
    input  wire logic [31:0] i_rnd,
    // request to the block
    output hsc_cfg_req_s     o_cfg
);
    initial o_cfg = '0;
    // req follows i_en each cycle, so it stays high while enabled; idle data toggles so stale fields never look valid
    always @(posedge i_core_clk)
    begin
        o_cfg.req   <= i_en;
        o_cfg.we    <= i_rnd[0];
        o_cfg.addr  <= i_rnd[1] ? 6'h39 : i_rnd[7:2];
        o_cfg.be_n  <= i_rnd[1] ? 4'h0 : i_rnd[11:8];
        o_cfg.wdata <= i_en ? i_rnd : ~o_cfg.wdata;
    end
endmodule

/* verification/hsc_regs_chk.sv */
`timescale 1ns/1ns
module hsc_regs_chk
    import hsc_pkg::*;
(
    // clock, reset, request
    input wire logic         i_core_clk,
    input wire logic         i_arst_n,
    input wire hsc_cfg_req_s i_cfg,
    input wire logic         i_removal_req,
    input wire logic         i_ejector_closed,
    // observed outputs
    input wire logic         o_cfg_ack,
    input wire logic [31:0]  o_cfg_rdata,
    input wire logic         o_bus_quiet,
    input wire logic         o_enum_out_n,
    input wire logic         o_led_on
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    // ----------------------------------------
    // hiding and answers
    // ----------------------------------------
    a_hide_armed: assert property (!$past(i_arst_n) |-> ##1 o_bus_quiet)
        else $error("hide not armed");
    a_hidden_silent: assert property (o_bus_quiet && $past(o_bus_quiet) |-> !o_cfg_ack)
        else $error("ack while hidden");
    a_open_answers: assert property (i_cfg.req && !o_bus_quiet && $past(i_arst_n) |=> o_cfg_ack)
        else $error("no ack");
    a_cap_ids: assert property (o_cfg_ack && !$past(i_cfg.we) && $past(i_cfg.addr) == 6'h39
        |-> o_cfg_rdata[15:0] == 16'h0006) else $error("id bytes");
    a_ro_fields: assert property (o_cfg_ack && !$past(i_cfg.we) && $past(i_cfg.addr) == 6'h39
        |-> o_cfg_rdata[21:20] == 2'h1 && !o_cfg_rdata[18]) else $error("ro field");
    a_led_write: assert property (o_cfg_ack && $past(i_cfg.we) && $past(i_cfg.addr) == 6'h39
        && !$past(i_cfg.be_n[2]) |-> o_led_on == $past(i_cfg.wdata[19])) else $error("led");
    // enumeration pin; mask stays 0 while hidden unless written on the first edge after release
    a_removal_enum: assert property (i_removal_req && o_bus_quiet |=> !o_enum_out_n)
        else $error("removal enum");
    a_seat_enum: assert property (i_ejector_closed && o_bus_quiet |=> !o_enum_out_n)
        else $error("seat enum");
    a_enum_sticky: assert property (!o_enum_out_n && o_bus_quiet |=> !o_enum_out_n)
        else $error("enum dropped");
    c_hidden: cover property (o_bus_quiet);
    c_enum: cover property ($fell(o_enum_out_n));
    c_removal: cover property (i_removal_req && o_bus_quiet);
endmodule
bind hsc_regs hsc_regs_chk hsc_regs_chk_i (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_cfg(i_cfg), .i_removal_req(i_removal_req), .i_ejector_closed(i_ejector_closed),
    .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata), .o_bus_quiet(o_bus_quiet),
    .o_enum_out_n(o_enum_out_n), .o_led_on(o_led_on));

/* verification/hsc_regs_test.sv */
`timescale 1ns/1ns
module hsc_regs_test
    import hsc_pkg::*;
;
    logic         core_clk, arst_n, en, removal_req, ejector_closed;
    logic         cfg_ack, bus_quiet, enum_out_n, led_on;
    logic [31:0]  cfg_rdata, rnd;
    hsc_cfg_req_s cfg;
    bit           m_hide, m_rem, m_fresh;
    int           error_cnt, compares;
    hsc_cfg_master hsc_cfg_master_i (.i_core_clk(core_clk), .i_en(en), .i_rnd(rnd), .o_cfg(cfg));
    hsc_regs hsc_regs_i (.i_core_clk(core_clk), .i_arst_n(arst_n), .i_cfg(cfg), .o_cfg_ack(cfg_ack),
        .o_cfg_rdata(cfg_rdata), .i_removal_req(removal_req), .i_ejector_closed(ejector_closed),
        .o_bus_quiet(bus_quiet), .o_enum_out_n(enum_out_n), .o_led_on(led_on));
    // ----------------------------------------
    // clock, random source, model
    // ----------------------------------------
    initial core_clk = 0;
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) rnd <= {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    // sticky flags; nothing can clear them once hidden
    always @(posedge core_clk or negedge arst_n)
        if (!arst_n)
            {m_hide, m_rem, m_fresh} = 3'h0;
        else
        begin
            // closure only counts once the edge after release has passed
            m_fresh |= ejector_closed && m_hide;
            m_hide = 1;
            m_rem |= removal_req;
        end
    task automatic chk1(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // outputs settle well before the falling edge
    always @(negedge core_clk)
    begin
        chk1(bus_quiet, m_hide, "quiet");
        chk1(enum_out_n, !(m_rem | m_fresh), "enum");
        chk1(led_on, 1'b0, "led");
        chk1(cfg_ack, 1'b0, "ack");
        chk32(cfg_rdata, 32'h0, "rdata");
    end
    task end_sim;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        {arst_n, en, removal_req} = 3'h0;
        ejector_closed = 1;
        rnd = 32'he9ef;
        repeat (2) @(posedge core_clk);
        arst_n <= 1;
        repeat (3) @(posedge core_clk);
        en <= 1; // random reads and unhide writes, all refused
        repeat (40) @(posedge core_clk);
        {en, ejector_closed, arst_n} <= 3'h0; // second reset, handle open
        repeat (2) @(posedge core_clk);
        arst_n <= 1;
        repeat (5) @(posedge core_clk);
        removal_req <= 1;
        @(posedge core_clk);
        removal_req <= 0;
        repeat (5) @(posedge core_clk);
        ejector_closed <= 1;
        repeat (5) @(posedge core_clk);
        end_sim;
    end
    // run needs about 63 cycles; generous margin
    initial
    begin
        repeat (500) @(posedge core_clk);
        error_cnt++;
        end_sim;
    end
endmodule
